//--- rtl/dram_txn_pkg.sv
// Package for the paged DRAM transaction link: widths, timing counts, controller states.
// Assumes both ends count timing in request-clock cycles.
package dram_txn_pkg;

  localparam int DQ_W      = 16;
  localparam int BANK_W    = 3;
  localparam int ROW_W     = 2;
  localparam int COL_W     = 2;
  localparam int NUM_BANKS = 8;
  localparam int MEM_AW    = BANK_W + ROW_W + COL_W + 1;
  localparam int MEM_WORDS = 256;
  localparam int WORDS     = 4;

  // Core timing, in request-clock cycles
  localparam int COLUMN_CYCLE_TIME          = 2;
  localparam int WRITE_DATA_DELAY           = 4;
  localparam int READ_DATA_DELAY            = 6;
  localparam int PRECHARGE_PERIOD           = 6;
  localparam int ROW_TO_COL_WRITE_DELAY     = 1;
  localparam int ROW_TO_COL_READ_DELAY      = 5;
  localparam int WRITE_TO_PRECHARGE_TIME    = 11;
  localparam int READ_TO_PRECHARGE_TIME     = 3;
  localparam int ACTIVATE_TO_PRECHARGE_MIN  = 8;

  // Controller wait counters and elapsed-time timers
  localparam int CNT_W   = 4;
  localparam int TIMER_W = 5;
  localparam logic [CNT_W-1:0] CNT_CC   = CNT_W'(COLUMN_CYCLE_TIME - 1);
  localparam logic [CNT_W-1:0] CNT_RP   = CNT_W'(PRECHARGE_PERIOD - 1);
  localparam logic [CNT_W-1:0] CNT_RCDW = CNT_W'(ROW_TO_COL_WRITE_DELAY - 1);
  localparam logic [CNT_W-1:0] CNT_RCDR = CNT_W'(ROW_TO_COL_READ_DELAY - 1);
  localparam logic [TIMER_W-1:0] TMR_WRP = TIMER_W'(WRITE_TO_PRECHARGE_TIME - 1);
  localparam logic [TIMER_W-1:0] TMR_RDP = TIMER_W'(READ_TO_PRECHARGE_TIME - 1);
  localparam logic [TIMER_W-1:0] TMR_RAS = TIMER_W'(ACTIVATE_TO_PRECHARGE_MIN - 1);

  // Column pipeline depths
  localparam int CTL_DEPTH = READ_DATA_DELAY + 2;
  localparam int DEV_DEPTH = READ_DATA_DELAY + 1;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_MISS_PRE  = 3'h1,
    ST_ACT_WAIT  = 3'h3,
    ST_COL_WAIT  = 3'h2,
    ST_DRAIN     = 3'h6,
    ST_CLOSE_PRE = 3'h7,
    ST_DONE      = 3'h5
  } ctl_state_t;

endpackage

//--- rtl/dram_link_if.sv
// Request and data link between the transaction controller and the DRAM end.
// Assumes the controller makes req_clk; the shared data bus is resolved here from the enables.
interface dram_link_if;
  logic                              req_clk;
  logic                              act_valid;
  logic                              pre_valid;
  logic                              col_valid;
  logic                              col_write;
  logic                              column_delay_field;
  logic [dram_txn_pkg::BANK_W-1:0]   bank;
  logic [dram_txn_pkg::ROW_W-1:0]    row;
  logic [dram_txn_pkg::COL_W-1:0]    col;
  logic [dram_txn_pkg::DQ_W-1:0]     ctl_dq_out;
  logic                              ctl_dq_oe;
  logic [dram_txn_pkg::DQ_W-1:0]     dev_dq_out;
  logic                              dev_dq_oe;
  logic [dram_txn_pkg::DQ_W-1:0]     dq;

  // Idle bus reads as zero
  assign dq = ctl_dq_oe ? ctl_dq_out : (dev_dq_oe ? dev_dq_out : '0);

  modport ctl (
    output req_clk, act_valid, pre_valid, col_valid, col_write, column_delay_field,
    output bank, row, col, ctl_dq_out, ctl_dq_oe,
    input  dq
  );

  modport dev (
    input  req_clk, act_valid, pre_valid, col_valid, col_write, column_delay_field,
    input  bank, row, col, dq,
    output dev_dq_out, dev_dq_oe
  );
endinterface

//--- rtl/dram_dev_end.sv
// DRAM end of the link: bank rows, column pipeline, write capture, read return.
// Assumes req_clk from the controller and commands that already keep core timing.
module dram_dev_end (
  dram_link_if.dev                          link,
  input  wire logic                         rst_n,
  output logic [dram_txn_pkg::NUM_BANKS-1:0] bank_open
);
  localparam int D   = dram_txn_pkg::DEV_DEPTH;
  localparam int CWD = dram_txn_pkg::WRITE_DATA_DELAY;
  localparam int CAC = dram_txn_pkg::READ_DATA_DELAY;
  localparam int AW  = dram_txn_pkg::MEM_AW - 1;

  logic [dram_txn_pkg::ROW_W-1:0]  open_row [dram_txn_pkg::NUM_BANKS];
  logic [dram_txn_pkg::DQ_W-1:0]   mem      [dram_txn_pkg::MEM_WORDS];
  logic                            dly_v;
  logic                            dly_w;
  logic [dram_txn_pkg::BANK_W-1:0] dly_bank;
  logic [dram_txn_pkg::COL_W-1:0]  dly_col;
  logic                            eff_v;
  logic                            eff_w;
  logic [dram_txn_pkg::BANK_W-1:0] eff_bank;
  logic [dram_txn_pkg::COL_W-1:0]  eff_col;
  logic [D-1:0]                    pv;
  logic [D-1:0]                    pw;
  logic [AW-1:0]                   pa [D];

  always_ff @(posedge link.req_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_v    <= 1'b0;
      dly_w    <= 1'b0;
      dly_bank <= '0;
      dly_col  <= '0;
    end else begin
      dly_v    <= link.col_valid && link.column_delay_field;
      dly_w    <= link.col_write;
      dly_bank <= link.bank;
      dly_col  <= link.col;
    end
  end

  always_comb begin
    if (dly_v) begin
      eff_v    = 1'b1;
      eff_w    = dly_w;
      eff_bank = dly_bank;
      eff_col  = dly_col;
    end else begin
      eff_v    = link.col_valid && !link.column_delay_field;
      eff_w    = link.col_write;
      eff_bank = link.bank;
      eff_col  = link.col;
    end
  end

  // Sense-amp state per bank; the device never compares rows itself
  always_ff @(posedge link.req_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open <= '0;
      for (int i = 0; i < dram_txn_pkg::NUM_BANKS; i++) begin
        open_row[i] <= '0;
      end
    end else if (link.act_valid) begin
      bank_open[link.bank] <= 1'b1;
      open_row[link.bank]  <= link.row;
    end else if (link.pre_valid) begin
      bank_open[link.bank] <= 1'b0;
    end
  end

  // Column pipeline: stage k holds a column k+1 cycles old
  always_ff @(posedge link.req_clk or negedge rst_n) begin
    if (!rst_n) begin
      pv <= '0;
      pw <= '0;
      for (int i = 0; i < D; i++) begin
        pa[i] <= '0;
      end
    end else begin
      pv    <= {pv[D-2:0], eff_v};
      pw    <= {pw[D-2:0], eff_w};
      pa[0] <= {eff_bank, open_row[eff_bank], eff_col};
      for (int i = 1; i < D; i++) begin
        pa[i] <= pa[i-1];
      end
    end
  end

  always_ff @(posedge link.req_clk) begin
    if (pv[CWD-1] && pw[CWD-1]) begin
      mem[{pa[CWD-1], 1'b0}] <= link.dq;
    end
    if (pv[CWD] && pw[CWD]) begin
      mem[{pa[CWD], 1'b1}] <= link.dq;
    end
  end

  always_ff @(posedge link.req_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.dev_dq_oe  <= 1'b0;
      link.dev_dq_out <= '0;
    end else if (pv[CAC-1] && !pw[CAC-1]) begin
      link.dev_dq_oe  <= 1'b1;
      link.dev_dq_out <= mem[{pa[CAC-1], 1'b0}];
    end else if (pv[CAC] && !pw[CAC]) begin
      link.dev_dq_oe  <= 1'b1;
      link.dev_dq_out <= mem[{pa[CAC], 1'b1}];
    end else begin
      link.dev_dq_oe  <= 1'b0;
      link.dev_dq_out <= '0;
    end
  end
endmodule // dram_dev_end

//--- rtl/dram_txn_ctl.sv
// Transaction controller end: bank tracking, packet sequencing, write data and read capture.
// Assumes one user request at a time; req_clk is made here as sys_clk divided by two.
//
// Summary of operation
// - Controller compares requested row with open row
// - Page hit issues only column packets
// - Column packets spaced by column cycle time
// - Each write packet spans one column cycle
// - Each read packet spans one column cycle
// - Write data driven at write data delay
// - Read data returned at read data delay
// - Miss: precharge, wait precharge period, activate
// - Empty: activate, wait row-to-column delay
// - Remember banks left closed
// - Precharge waits write-to-precharge after writes
// - Precharge waits read-to-precharge after reads
// - Closing the bank is page policy
// - Activate to precharge at least minimum time
// - Precharge spacing takes larger of both limits
// - Delayed packet equals later undelayed packet
module dram_txn_ctl (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rst_n,
  dram_link_if.ctl                                  link,
  input  wire logic                                 req_valid,
  output logic                                      req_ready,
  input  wire logic                                 req_write,
  input  wire logic [dram_txn_pkg::BANK_W-1:0]      req_bank,
  input  wire logic [dram_txn_pkg::ROW_W-1:0]       req_row,
  input  wire logic [dram_txn_pkg::COL_W-1:0]       req_col,
  input  wire logic                                 req_two,
  input  wire logic                                 req_close,
  input  wire logic [dram_txn_pkg::WORDS*dram_txn_pkg::DQ_W-1:0] req_wdata,
  output logic                                      rsp_valid,
  output logic [dram_txn_pkg::WORDS*dram_txn_pkg::DQ_W-1:0] rsp_rdata
);
  localparam int D   = dram_txn_pkg::CTL_DEPTH;
  localparam int CWD = dram_txn_pkg::WRITE_DATA_DELAY;
  localparam int CAC = dram_txn_pkg::READ_DATA_DELAY;
  localparam int W   = dram_txn_pkg::DQ_W;

  dram_txn_pkg::ctl_state_t                 state;
  logic                                     lclk;
  logic                                     tick;
  logic [dram_txn_pkg::CNT_W-1:0]           cnt;
  logic                                     cur_write;
  logic                                     cur_two;
  logic                                     cur_close;
  logic                                     second;
  logic [dram_txn_pkg::BANK_W-1:0]          cur_bank;
  logic [dram_txn_pkg::ROW_W-1:0]           cur_row;
  logic [dram_txn_pkg::COL_W-1:0]           cur_col;
  logic [dram_txn_pkg::DQ_W-1:0]            wr_word [dram_txn_pkg::WORDS];
  logic [dram_txn_pkg::NUM_BANKS-1:0]       is_open;
  logic [dram_txn_pkg::ROW_W-1:0]           open_row [dram_txn_pkg::NUM_BANKS];
  logic [dram_txn_pkg::TIMER_W-1:0]         since_act;
  logic [dram_txn_pkg::TIMER_W-1:0]         since_col;
  logic                                     last_wr;
  logic [D-1:0]                             cp_v;
  logic [D-1:0]                             cp_w;
  logic [D-1:0]                             cp_n;
  logic                                     pre_ok;
  logic                                     do_pre;
  logic                                     do_act;
  logic                                     do_col;

  // Link clock made by division; tick marks the edge where it falls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk <= 1'b0;
    end else begin
      lclk <= ~lclk;
    end
  end

  assign link.req_clk = lclk;
  assign tick         = lclk;

  assign pre_ok = (since_act >= dram_txn_pkg::TMR_RAS) &&
                  (since_col >= (last_wr ? dram_txn_pkg::TMR_WRP : dram_txn_pkg::TMR_RDP));
  assign do_pre = tick && pre_ok &&
                  (state == dram_txn_pkg::ST_MISS_PRE || state == dram_txn_pkg::ST_CLOSE_PRE);
  assign do_act = tick && (state == dram_txn_pkg::ST_ACT_WAIT) && (cnt == '0);
  assign do_col = tick && (state == dram_txn_pkg::ST_COL_WAIT) && (cnt == '0);

  // Sequencer and request packets
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state                   <= dram_txn_pkg::ST_IDLE;
      cnt                     <= '0;
      req_ready               <= 1'b1;
      rsp_valid               <= 1'b0;
      cur_write               <= 1'b0;
      cur_two                 <= 1'b0;
      cur_close               <= 1'b0;
      second                  <= 1'b0;
      cur_bank                <= '0;
      cur_row                 <= '0;
      cur_col                 <= '0;
      link.act_valid          <= 1'b0;
      link.pre_valid          <= 1'b0;
      link.col_valid          <= 1'b0;
      link.col_write          <= 1'b0;
      link.column_delay_field <= 1'b0;
      link.bank               <= '0;
      link.row                <= '0;
      link.col                <= '0;
      for (int i = 0; i < dram_txn_pkg::WORDS; i++) begin
        wr_word[i] <= '0;
      end
    end else begin
      rsp_valid <= 1'b0;
      if (state == dram_txn_pkg::ST_IDLE) begin
        if (req_valid && req_ready) begin
          req_ready <= 1'b0;
          cur_write <= req_write;
          cur_two   <= req_two;
          cur_close <= req_close;
          second    <= 1'b0;
          cur_bank  <= req_bank;
          cur_row   <= req_row;
          cur_col   <= req_col;
          cnt       <= '0;
          for (int i = 0; i < dram_txn_pkg::WORDS; i++) begin
            wr_word[i] <= req_wdata[i*W +: W];
          end
          if (is_open[req_bank] && open_row[req_bank] == req_row) begin
            state <= dram_txn_pkg::ST_COL_WAIT;
          end else if (is_open[req_bank]) begin
            state <= dram_txn_pkg::ST_MISS_PRE;
          end else begin
            state <= dram_txn_pkg::ST_ACT_WAIT;
          end
        end
      end else if (tick) begin
        // Each packet stands for exactly one request cycle
        link.act_valid <= do_act;
        link.pre_valid <= do_pre;
        link.col_valid <= do_col;
        link.column_delay_field <= 1'b0;
        if (do_act || do_pre || do_col) begin
          link.bank      <= cur_bank;
          link.row       <= cur_row;
          link.col       <= cur_col;
          link.col_write <= cur_write;
        end
        unique case (state)
          dram_txn_pkg::ST_MISS_PRE: begin
            if (do_pre) begin
              state <= dram_txn_pkg::ST_ACT_WAIT;
              cnt   <= dram_txn_pkg::CNT_RP;
            end
          end
          dram_txn_pkg::ST_ACT_WAIT: begin
            if (cnt != '0) begin
              cnt <= cnt - 1'b1;
            end else begin
              state <= dram_txn_pkg::ST_COL_WAIT;
              cnt   <= cur_write ? dram_txn_pkg::CNT_RCDW : dram_txn_pkg::CNT_RCDR;
            end
          end
          dram_txn_pkg::ST_COL_WAIT: begin
            if (cnt != '0) begin
              cnt <= cnt - 1'b1;
            end else if (cur_two && !second) begin
              second  <= 1'b1;
              cur_col <= cur_col + 1'b1;
              cnt     <= dram_txn_pkg::CNT_CC;
            end else begin
              state <= dram_txn_pkg::ST_DRAIN;
            end
          end
          dram_txn_pkg::ST_DRAIN: begin
            if (cp_v == '0) begin
              state <= cur_close ? dram_txn_pkg::ST_CLOSE_PRE : dram_txn_pkg::ST_DONE;
            end
          end
          dram_txn_pkg::ST_CLOSE_PRE: begin
            if (do_pre) begin
              state <= dram_txn_pkg::ST_DONE;
            end
          end
          dram_txn_pkg::ST_DONE: begin
            rsp_valid <= 1'b1;
            req_ready <= 1'b1;
            state     <= dram_txn_pkg::ST_IDLE;
          end
          default: begin
            state     <= dram_txn_pkg::ST_IDLE;
            req_ready <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_open <= '0;
      for (int i = 0; i < dram_txn_pkg::NUM_BANKS; i++) begin
        open_row[i] <= '0;
      end
    end else if (do_act) begin
      is_open[cur_bank]  <= 1'b1;
      open_row[cur_bank] <= cur_row;
    end else if (do_pre) begin
      is_open[cur_bank] <= 1'b0;
    end
  end

  // Elapsed request cycles; global timers are conservative across banks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      since_act <= '1;
      since_col <= '1;
      last_wr   <= 1'b0;
    end else if (tick) begin
      if (do_act) begin
        since_act <= '0;
      end else if (since_act != '1) begin
        since_act <= since_act + 1'b1;
      end
      if (do_col) begin
        since_col <= '0;
        last_wr   <= cur_write;
      end else if (since_col != '1) begin
        since_col <= since_col + 1'b1;
      end
    end
  end

  // Column pipeline, one stage per request cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_v <= '0;
      cp_w <= '0;
      cp_n <= '0;
    end else if (tick) begin
      cp_v <= {cp_v[D-2:0], do_col};
      cp_w <= {cp_w[D-2:0], cur_write};
      cp_n <= {cp_n[D-2:0], second};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.ctl_dq_oe  <= 1'b0;
      link.ctl_dq_out <= '0;
    end else if (tick) begin
      if (cp_v[CWD-1] && cp_w[CWD-1]) begin
        link.ctl_dq_oe  <= 1'b1;
        link.ctl_dq_out <= cp_n[CWD-1] ? wr_word[2] : wr_word[0];
      end else if (cp_v[CWD] && cp_w[CWD]) begin
        link.ctl_dq_oe  <= 1'b1;
        link.ctl_dq_out <= cp_n[CWD] ? wr_word[3] : wr_word[1];
      end else begin
        link.ctl_dq_oe  <= 1'b0;
        link.ctl_dq_out <= '0;
      end
    end
  end

  // Sample read data
  // Data comes from flops on req_clk, which is made here, so no synchroniser is needed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_rdata <= '0;
    end else if (tick) begin
      if (cp_v[CAC] && !cp_w[CAC]) begin
        if (cp_n[CAC]) begin
          rsp_rdata[2*W +: W] <= link.dq;
        end else begin
          rsp_rdata[0 +: W] <= link.dq;
        end
      end
      if (cp_v[CAC+1] && !cp_w[CAC+1]) begin
        if (cp_n[CAC+1]) begin
          rsp_rdata[3*W +: W] <= link.dq;
        end else begin
          rsp_rdata[1*W +: W] <= link.dq;
        end
      end
    end
  end
endmodule // dram_txn_ctl

//--- dv/dram_link_asserts.sv
// Timing checks on the controller to DRAM link, sampled on the link clock.
// Assumes instantiation in the bench beside the link interface; rst_n is async, active low.
module dram_link_asserts (
  input wire logic req_clk,
  input wire logic rst_n,
  input wire logic act_valid,
  input wire logic pre_valid,
  input wire logic col_valid,
  input wire logic col_write,
  input wire logic column_delay_field,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe
);
  logic wr;
  logic rd;

  // Delayed columns are not issued by the controller, so wr and rd count undelayed columns only
  assign wr = col_valid && col_write && !column_delay_field;
  assign rd = col_valid && !col_write && !column_delay_field;

  default clocking cb @(posedge req_clk);
  endclocking
  default disable iff (!rst_n);

  a_col_spacing: assert property (col_valid |=> !col_valid)
    else $error("column packets closer than a column cycle");
  a_wr_data_time: assert property (wr |-> ##4 ctl_dq_oe [*2])
    else $error("write data not driven at write data delay");
  a_wr_data_only: assert property (ctl_dq_oe |-> $past(wr, 4) || $past(wr, 5))
    else $error("write data driven outside its packet");
  a_rd_data_time: assert property (rd |-> ##7 dev_dq_oe [*2])
    else $error("read data not returned at read data delay");
  a_rd_data_only: assert property (dev_dq_oe |-> $past(rd, 7) || $past(rd, 8))
    else $error("read data driven outside its packet");
  a_pre_to_act: assert property (pre_valid |-> !act_valid ##1 (!act_valid) [*5])
    else $error("activate sooner than precharge period");
  a_act_to_wcol: assert property (act_valid |-> !col_valid)
    else $error("column in the cycle of its activate");
  a_act_to_rcol: assert property (act_valid |=> (!rd) [*4])
    else $error("read column sooner than row to column delay");
  a_wcol_to_pre: assert property (wr |-> (!pre_valid) [*8] ##1 (!pre_valid) [*3])
    else $error("precharge too soon after write column");
  a_rcol_to_pre: assert property (rd |-> (!pre_valid) [*3])
    else $error("precharge too soon after read column");
  a_act_to_pre: assert property (act_valid |-> (!pre_valid) [*8])
    else $error("precharge too soon after activate");
endmodule // dram_link_asserts

//--- dv/tb.sv
// Bench joining the transaction controller and the DRAM end over the link interface.
// Assumes the controller makes the link clock; packets are counted on the link itself.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DW = dram_txn_pkg::WORDS * dram_txn_pkg::DQ_W;
  localparam logic [DW-1:0] W1 = 64'hF00D_1234_5678_9ABC;
  localparam logic [DW-1:0] W2 = 64'h1111_2222_3333_4444;

  logic                                sys_clk;
  logic                                rst_n;
  logic                                req_valid;
  logic                                req_ready;
  logic                                req_write;
  logic [dram_txn_pkg::BANK_W-1:0]     req_bank;
  logic [dram_txn_pkg::ROW_W-1:0]      req_row;
  logic [dram_txn_pkg::COL_W-1:0]      req_col;
  logic                                req_two;
  logic                                req_close;
  logic [DW-1:0]                       req_wdata;
  logic                                rsp_valid;
  logic [DW-1:0]                       rsp_rdata;
  logic [dram_txn_pkg::NUM_BANKS-1:0]  bank_open;
  int                                  n_fail;
  int                                  compares;
  int                                  n_act;
  int                                  n_pre;
  int                                  n_col;

  dram_link_if link ();

  dram_txn_ctl u_dram_txn_ctl (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(req_row),
    .req_col(req_col), .req_two(req_two), .req_close(req_close), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata)
  );

  dram_dev_end u_dram_dev_end (.link(link), .rst_n(rst_n), .bank_open(bank_open));

  dram_link_asserts u_dram_link_asserts (
    .req_clk(link.req_clk), .rst_n(rst_n), .act_valid(link.act_valid),
    .pre_valid(link.pre_valid), .col_valid(link.col_valid), .col_write(link.col_write),
    .column_delay_field(link.column_delay_field), .ctl_dq_oe(link.ctl_dq_oe),
    .dev_dq_oe(link.dev_dq_oe)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Packets are counted on the wire, so a stray or missing row command shows up
  always @(posedge link.req_clk) begin
    n_act += int'(link.act_valid === 1'b1);
    n_pre += int'(link.pre_valid === 1'b1);
    n_col += int'(link.col_valid === 1'b1);
  end

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic hang(input string msg);
    n_fail++;
    $display("MISMATCH %0t timeout %s", $time, msg);
    finish_test();
  endtask

  task automatic do_req(input logic w, input logic [2:0] b, input logic [1:0] r,
                        input logic [1:0] c, input logic tw, input logic cl,
                        input logic [DW-1:0] wd);
    int i;
    @(negedge sys_clk);
    req_write = w;
    req_bank = b;
    req_row = r;
    req_col = c;
    req_two = tw;
    req_close = cl;
    req_wdata = wd;
    req_valid = 1'b1;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (i == 20) hang("ready");
    n_act = 0;
    n_pre = 0;
    n_col = 0;
    @(negedge sys_clk);
    req_valid = 1'b0;
    for (i = 0; i < 200 && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
    if (i == 200) hang("response");
  endtask

  task automatic pkts(input int a, input int p, input int c);
    check(n_act == a && n_pre == p && n_col == c, "packet counts");
  endtask

  // Two columns starting at col 3 also wrap the second column to col 0
  task automatic t_empty_write;
    do_req(1'b1, 3'h0, 2'h1, 2'h3, 1'b1, 1'b0, W1);
    pkts(1, 0, 2);
    check(bank_open === 8'h01, "bank not left open");
    $display("test empty_write done");
  endtask

  task automatic t_hit_read;
    do_req(1'b0, 3'h0, 2'h1, 2'h3, 1'b1, 1'b0, '0);
    pkts(0, 0, 2);
    check(rsp_rdata === W1, "hit read data");
    $display("test hit_read done");
  endtask

  task automatic t_miss_write;
    do_req(1'b1, 3'h0, 2'h2, 2'h1, 1'b0, 1'b1, W2);
    pkts(1, 2, 1);
    check(bank_open === 8'h00, "bank not closed");
    $display("test miss_write done");
  endtask

  // Single read: upper words must keep the previous read's value
  task automatic t_empty_read;
    do_req(1'b0, 3'h0, 2'h2, 2'h1, 1'b0, 1'b1, '0);
    pkts(1, 1, 1);
    check(rsp_rdata === {W1[63:32], W2[31:0]}, "empty read data");
    $display("test empty_read done");
  endtask

  // Hit write over an empty write, then a two-column miss read and a read-back
  task automatic t_hit_write_miss_read;
    do_req(1'b1, 3'h0, 2'h2, 2'h2, 1'b0, 1'b0, W1);
    pkts(1, 0, 1);
    do_req(1'b1, 3'h0, 2'h2, 2'h2, 1'b0, 1'b0, W2);
    pkts(0, 0, 1);
    do_req(1'b0, 3'h0, 2'h1, 2'h3, 1'b1, 1'b1, '0);
    pkts(1, 2, 2);
    check(rsp_rdata === W1, "miss read data");
    check(bank_open === 8'h00, "bank not closed after read");
    do_req(1'b0, 3'h0, 2'h2, 2'h2, 1'b0, 1'b1, '0);
    pkts(1, 1, 1);
    check(rsp_rdata === {W1[63:32], W2[31:0]}, "hit write data");
    $display("test hit_write_miss_read done");
  endtask

  task automatic t_reset;
    do_req(1'b1, 3'h7, 2'h3, 2'h0, 1'b0, 1'b0, W2);
    check(bank_open === 8'h80, "bank 7 not open");
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(bank_open === 8'h00 && req_ready === 1'b1 && rsp_valid === 1'b0, "reset state");
    rst_n = 1'b1;
    $display("test reset done");
  endtask

  initial begin
    n_fail = 0;
    compares = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_bank = '0;
    req_row = '0;
    req_col = '0;
    req_two = 1'b0;
    req_close = 1'b0;
    req_wdata = '0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    t_empty_write();
    t_hit_read();
    t_miss_write();
    t_empty_read();
    t_hit_write_miss_read();
    t_reset();
    finish_test();
  end
endmodule // tb
